//--- common/perf_event_pkg.sv
// constants, register map and event strobe bundle for the event select decoder
// assumes the pipeline strobes arrive on the core clock, one bit per cycle each
package perf_event_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 2;

  localparam logic [7:0] OFS_SEL_ZERO = 8'h00;
  localparam logic [7:0] OFS_SEL_ONE = 8'h04;
  localparam logic [7:0] OFS_CNT_ZERO = 8'h08;
  localparam logic [7:0] OFS_CNT_ONE = 8'h0C;

  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_MASK_LSB = 8;
  localparam int SEL_EN_BIT = 22;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_STEP = 32'h0000_0001;

  localparam logic [7:0] EV_RES_STALL = 8'hA2;
  localparam logic [7:0] EV_PARTIAL = 8'hD2;
  localparam logic [7:0] EV_SEG_LOAD = 8'h06;
  localparam logic [7:0] EV_UNHALTED = 8'h79;
  localparam logic [7:0] EV_SIMD_EXEC = 8'hB0;
  localparam logic [7:0] EV_SIMD_SAT = 8'hB1;
  localparam logic [7:0] EV_SIMD_UOP = 8'hB2;
  localparam logic [7:0] EV_SIMD_CLASS = 8'hB3;
  localparam logic [7:0] EV_FP_SWITCH = 8'hCC;
  localparam logic [7:0] EV_ASSIST = 8'hCD;
  localparam logic [7:0] EV_SIMD_RET = 8'hCE;
  localparam logic [7:0] EV_SEG_STALL = 8'hD4;
  localparam logic [7:0] EV_SEG_REN = 8'hD5;
  localparam logic [7:0] EV_SEG_RET = 8'hD6;
  localparam logic [7:0] EV_L2_QUAL = 8'h2E;
  localparam logic [7:0] EV_BUS_QUAL = 8'h60;

  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_REVERSE = 8'h01;
  localparam logic [7:0] MASK_UOP_ALL = 8'h0F;
  localparam int BUS_ANY_BIT = 5;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic stall_rename_buf;
    logic stall_mem_buf;
    logic stall_mispredict;
    logic stall_sync_drain;
    logic stall_bus_queue;
    logic stall_cache_miss;
    logic partial_alias_stall;
    logic seg_load;
    logic not_halted;
    logic simd_exec;
    logic simd_store_move;
    logic simd_saturate;
    logic simd_uop;
    logic [5:0] simd_class;
    logic simd_to_fp;
    logic fp_to_simd;
    logic simd_state_empty_op;
    logic simd_retire;
    logic [3:0] seg_rename_stall;
    logic [3:0] seg_rename;
    logic seg_rename_retire;
    logic l2_event;
    logic [1:0] l2_state;
    logic bus_event;
    logic bus_self;
  } events_t;
endpackage

//--- src/perf_event_select_decoder.sv
// event select decoder with two counters behind an AXI4-Lite slave
// assumes event strobes come from same-clock pipeline logic, so no synchroniser
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Function
// - code D2H, mask 00H counts partial alias stalls including flag stalls.
// - code 06H counts each segment register load.
// - code 79H counts every cycle the core is not halted.
// - code B0H counts executed packed SIMD ops, minus register-to-memory move stores.
// - code B1H counts executed saturating packed SIMD instructions.
// - code B3H mask bits pick multiply, shift, pack, unpack, logical, arithmetic.
// - code CCH mask 00H counts SIMD-to-FP switches, 01H the reverse.
// - code CDH counts each execution of the SIMD state empty instruction.
// - code CEH counts each retired packed SIMD instruction.
// - code D4H counts segment rename stalls, mask selecting segment registers.
// - code D5H counts segment renames, mask bits per segment, 0FH all.
// - code D6H, mask 00H counts retired segment rename events.
// - L2 events: mask bits 3..0 enable modified, exclusive, shared, invalid.
// - L2 events with mask zero count nothing; software sets all four bits.
// - bus events: mask bit 5 clear counts own transactions, set counts any.
// - resource stalls exclude bus queue and miss stalls, include recovery, drain.
// - code A2H, mask 00H adds one per cycle with a resource stall present.
module perf_event_select_decoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire perf_event_pkg::events_t events,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [31:0] sel [perf_event_pkg::NUM_CH];
  logic [31:0] count [perf_event_pkg::NUM_CH];
  logic [31:0] next_sel [perf_event_pkg::NUM_CH];
  logic [31:0] next_count [perf_event_pkg::NUM_CH];
  logic [perf_event_pkg::NUM_CH-1:0] hit;

  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_full;
  logic next_w_full;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // byte lanes let software preset one part of a counter and keep the rest
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic decode(input logic [31:0] cfg,
                                  input perf_event_pkg::events_t ev);
    logic [7:0] code;
    logic [7:0] mask;
    logic stall;
    logic result;
    code = cfg[perf_event_pkg::SEL_CODE_LSB +: 8];
    mask = cfg[perf_event_pkg::SEL_MASK_LSB +: 8];
    // queue-full and miss stalls are deliberately left out of the sum
    stall = ev.stall_rename_buf | ev.stall_mem_buf | ev.stall_mispredict
          | ev.stall_sync_drain;
    result = 1'b0;
    case (code)
      perf_event_pkg::EV_RES_STALL: begin
        result = (mask == perf_event_pkg::MASK_NONE) & stall;
      end
      perf_event_pkg::EV_PARTIAL: begin
        result = (mask == perf_event_pkg::MASK_NONE) & ev.partial_alias_stall;
      end
      perf_event_pkg::EV_SEG_LOAD: begin
        result = ev.seg_load;
      end
      perf_event_pkg::EV_UNHALTED: begin
        result = ev.not_halted;
      end
      perf_event_pkg::EV_SIMD_EXEC: begin
        result = ev.simd_exec & ~ev.simd_store_move;
      end
      perf_event_pkg::EV_SIMD_SAT: begin
        result = ev.simd_saturate;
      end
      perf_event_pkg::EV_SIMD_UOP: begin
        result = (mask == perf_event_pkg::MASK_UOP_ALL) & ev.simd_uop;
      end
      perf_event_pkg::EV_SIMD_CLASS: begin
        // several mask bits may be set; a class hit in any of them counts once
        result = |(mask[5:0] & ev.simd_class);
      end
      perf_event_pkg::EV_FP_SWITCH: begin
        if (mask == perf_event_pkg::MASK_NONE) begin
          result = ev.simd_to_fp;
        end else if (mask == perf_event_pkg::MASK_REVERSE) begin
          result = ev.fp_to_simd;
        end
      end
      perf_event_pkg::EV_ASSIST: begin
        result = ev.simd_state_empty_op;
      end
      perf_event_pkg::EV_SIMD_RET: begin
        result = ev.simd_retire;
      end
      perf_event_pkg::EV_SEG_STALL: begin
        result = |(mask[3:0] & ev.seg_rename_stall);
      end
      perf_event_pkg::EV_SEG_REN: begin
        result = |(mask[3:0] & ev.seg_rename);
      end
      perf_event_pkg::EV_SEG_RET: begin
        result = (mask == perf_event_pkg::MASK_NONE) & ev.seg_rename_retire;
      end
      perf_event_pkg::EV_L2_QUAL: begin
        // a zero mask enables no state and so never counts
        result = ev.l2_event & mask[ev.l2_state];
      end
      perf_event_pkg::EV_BUS_QUAL: begin
        result = ev.bus_event & (mask[perf_event_pkg::BUS_ANY_BIT] | ev.bus_self);
      end
      default: begin
        result = 1'b0;
      end
    endcase
    return result;
  endfunction

  // the select as it stood before this edge qualifies the count, so a freshly
  // written code starts counting one cycle after the write lands
  for (genvar i = 0; i < perf_event_pkg::NUM_CH; i++) begin : g_ch
    assign hit[i] = sel[i][perf_event_pkg::SEL_EN_BIT] & decode(sel[i], events);
  end

  always_comb begin
    logic do_write;
    logic [31:0] merged;
    do_write = 1'b0;
    merged = 32'h0000_0000;
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    for (int i = 0; i < perf_event_pkg::NUM_CH; i++) begin
      next_sel[i] = sel[i];
      next_count[i] = hit[i] ? count[i] + perf_event_pkg::CNT_STEP : count[i];
    end

    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end

    // a write is performed only once the previous response has been taken
    if (aw_full && w_full && !s_axi_bvalid) begin
      do_write = 1'b1;
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = perf_event_pkg::RESP_OKAY;
    end
    if (do_write) begin
      // a software write to a counter wins over a same-cycle increment
      unique case (aw_addr)
        perf_event_pkg::OFS_SEL_ZERO: begin
          next_sel[0] = merge_bytes(sel[0], w_data, w_strb);
        end
        perf_event_pkg::OFS_SEL_ONE: begin
          next_sel[1] = merge_bytes(sel[1], w_data, w_strb);
        end
        perf_event_pkg::OFS_CNT_ZERO: begin
          merged = merge_bytes(count[0], w_data, w_strb);
          next_count[0] = merged;
        end
        perf_event_pkg::OFS_CNT_ONE: begin
          merged = merge_bytes(count[1], w_data, w_strb);
          next_count[1] = merged;
        end
        default: begin
          next_bresp = perf_event_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // the read is a snapshot at the handshake edge; later increments show only
    // on the next read
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = perf_event_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        perf_event_pkg::OFS_SEL_ZERO: next_rdata = sel[0];
        perf_event_pkg::OFS_SEL_ONE: next_rdata = sel[1];
        perf_event_pkg::OFS_CNT_ZERO: next_rdata = count[0];
        perf_event_pkg::OFS_CNT_ONE: next_rdata = count[1];
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = perf_event_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ready is the inverse of the held slot, so at most one read is in flight; a second
    // write can be taken and held while the previous write response is still unanswered
    next_awready = !next_aw_full;
    next_wready = !next_w_full;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clock) begin
    // reset does not wait for the clock enable, so a frozen block can be cleared
    if (!rst_n) begin
      for (int i = 0; i < perf_event_pkg::NUM_CH; i++) begin
        sel[i] <= perf_event_pkg::SEL_RESET;
        count[i] <= perf_event_pkg::CNT_RESET;
      end
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      for (int i = 0; i < perf_event_pkg::NUM_CH; i++) begin
        sel[i] <= next_sel[i];
        count[i] <= next_count[i];
      end
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

`default_nettype wire

//--- test/perf_event_props.sv
// bus timing checker for the event select decoder
// assumes it is bound to the decoder top and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module perf_event_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic ar_map = s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0;
  wire logic ar_go = s_axi_arvalid && s_axi_arready;
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence write_done;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (both_taken |=> write_done) else $error("late bvalid");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("rdata moved");
  chk_read_answer: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready) else $error("late rvalid");
  chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during read");
  chk_unmapped_read: assert property (ar_go && !ar_map |=>
    s_axi_rresp == perf_event_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad slverr");
  chk_mapped_read: assert property (ar_go && ar_map |=>
    s_axi_rresp == perf_event_pkg::RESP_OKAY) else $error("bad okay");
  chk_ready_return: assert property ($rose(rst_n) |=>
    s_axi_awready && s_axi_wready && s_axi_arready) else $error("ready missing");
endmodule
bind perf_event_select_decoder perf_event_props perf_event_props_inst (.*);
`default_nettype wire

//--- test/pipeline_event_model.sv
// behavioural pipeline: holds one event pattern for len cycles per request
// assumes start is a one-cycle pulse from the bench on the core clock
`timescale 1ns/10ps
`default_nettype none
module pipeline_event_model #(parameter int LEN = 4) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire perf_event_pkg::events_t pat,
  output perf_event_pkg::events_t events,
  output logic busy
);
  int cnt = 0;
  assign busy = cnt != 0;
  always @(posedge clock) begin
    if (!rst_n) begin
      events <= '0;
      cnt <= 0;
    end else if (start) begin
      events <= pat;
      cnt <= LEN;
    end else if (cnt != 0) begin
      // strobes drop after len sampled cycles so nothing leaks into the read
      if (cnt == 1)
        events <= '0;
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the event select decoder
// assumes the package is compiled first; the pipeline model drives events
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  perf_event_pkg::events_t events;
  perf_event_pkg::events_t pat = '0;
  logic start = 1'b0;
  logic busy;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  initial forever #10 clock = ~clock;
  perf_event_select_decoder perf_event_select_decoder_inst (.clock, .rst_n, .clk_en, .events,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pipeline_event_model pipeline_event_model_inst (.clock, .rst_n, .start, .pat, .events, .busy);
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // each case clears counter zero, enables it, plays four event cycles, reads back
  task automatic run(input logic [7:0] code, input logic [7:0] mask,
                     input perf_event_pkg::events_t ev, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(perf_event_pkg::OFS_CNT_ZERO, 32'h0, r);
    axi_wr(perf_event_pkg::OFS_SEL_ZERO, {9'h0, 1'b1, 6'h0, mask, code}, r);
    pat <= ev;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do @(posedge clock); while (busy);
    axi_rd(perf_event_pkg::OFS_CNT_ZERO, d, r);
    check($sformatf("count %h/%h", code, mask), d, exp);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    axi_wr(8'h10, 32'h1, r);
    check("bresp", {30'h0, r}, {30'h0, perf_event_pkg::RESP_SLVERR});
    axi_rd(8'h10, d, r);
    check("rresp", {30'h0, r}, {30'h0, perf_event_pkg::RESP_SLVERR});
    axi_wr(perf_event_pkg::OFS_CNT_ONE, 32'hA5A5_5A5A, r);
    axi_rd(perf_event_pkg::OFS_CNT_ONE, d, r);
    check("counter one", d, 32'hA5A5_5A5A);
    axi_wr(perf_event_pkg::OFS_SEL_ONE, 32'h0040_0006, r);
    axi_rd(perf_event_pkg::OFS_SEL_ONE, d, r);
    check("select one", d, 32'h0040_0006);
    run(8'hA2, 8'h00, '{default: '0, stall_mispredict: '1}, 4);
    run(8'hA2, 8'h00, '{default: '0, stall_rename_buf: '1, stall_mem_buf: '1}, 4);
    run(8'hA2, 8'h00, '{default: '0, stall_sync_drain: '1}, 4);
    run(8'hA2, 8'h00, '{default: '0, stall_bus_queue: '1, stall_cache_miss: '1}, 0);
    run(8'hD2, 8'h00, '{default: '0, partial_alias_stall: '1}, 4);
    run(8'hD2, 8'h01, '{default: '0, partial_alias_stall: '1}, 0);
    run(8'h06, 8'h00, '{default: '0, seg_load: '1}, 4);
    run(8'h79, 8'h00, '{default: '0, not_halted: '1}, 4);
    // clock enable low: the same strobes must leave the counter frozen
    clk_en <= 1'b0;
    pat <= '{default: '0, not_halted: '1};
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do @(posedge clock); while (busy);
    clk_en <= 1'b1;
    axi_rd(perf_event_pkg::OFS_CNT_ZERO, d, r);
    check("frozen count", d, 32'h0000_0004);
    run(8'hB0, 8'h00, '{default: '0, simd_exec: '1}, 4);
    run(8'hB0, 8'h00, '{default: '0, simd_exec: '1, simd_store_move: '1}, 0);
    run(8'hB1, 8'h00, '{default: '0, simd_saturate: '1}, 4);
    run(8'hB2, 8'h0F, '{default: '0, simd_uop: '1}, 4);
    for (int i = 0; i < 6; i++)
      run(8'hB3, 8'h01 << i, '{default: '0, simd_class: 6'h01 << i}, 4);
    run(8'hB3, 8'h01, '{default: '0, simd_class: 6'h3E}, 0);
    run(8'hCC, 8'h00, '{default: '0, simd_to_fp: '1}, 4);
    run(8'hCC, 8'h00, '{default: '0, fp_to_simd: '1}, 0);
    run(8'hCC, 8'h01, '{default: '0, fp_to_simd: '1}, 4);
    run(8'hCD, 8'h00, '{default: '0, simd_state_empty_op: '1}, 4);
    run(8'hCE, 8'h00, '{default: '0, simd_retire: '1}, 4);
    run(8'hD4, 8'h04, '{default: '0, seg_rename_stall: 4'h4}, 4);
    run(8'hD4, 8'h04, '{default: '0, seg_rename_stall: 4'h2}, 0);
    for (int i = 0; i < 4; i++)
      run(8'hD5, 8'h01 << i, '{default: '0, seg_rename: 4'h1 << i}, 4);
    run(8'hD5, 8'h0F, '{default: '0, seg_rename: 4'h8}, 4);
    run(8'hD6, 8'h00, '{default: '0, seg_rename_retire: '1}, 4);
    for (int i = 0; i < 4; i++)
      run(8'h2E, 8'h01 << i, '{default: '0, l2_event: '1, l2_state: i[1:0]}, 4);
    run(8'h2E, 8'h08, '{default: '0, l2_event: '1, l2_state: 2'h0}, 0);
    run(8'h2E, 8'h00, '{default: '0, l2_event: '1, l2_state: 2'h3}, 0);
    run(8'h60, 8'h00, '{default: '0, bus_event: '1}, 0);
    run(8'h60, 8'h00, '{default: '0, bus_event: '1, bus_self: '1}, 4);
    run(8'h60, 8'h20, '{default: '0, bus_event: '1}, 4);
    run(8'h55, 8'h00, '{default: '0, not_halted: '1}, 0);
    axi_rd(perf_event_pkg::OFS_CNT_ONE, d, r);
    check("counter one count", d, 32'hA5A5_5A5E);
    print_verdict();
  end
endmodule
`default_nettype wire
